// *** design/tcml_top.sv ***
/*
 * Three independent 16-bit down-counters with six waveform modes,
 * programmed through an APB slave (count registers and control word).
 * Assumes count clock and gate inputs synchronous to pclk and slower than it.
 */
`timescale 1ns/1ps
`default_nettype none
module tcml_top
    import tcml_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] count_clock_in,
    input wire logic [2:0] count_gate_in,
    output logic [2:0] counter_wave_out
);
    // =========================================================
    // Helper functions
    // Decimal decrement over four decades with borrow
    function automatic logic [15:0] tcml_bcd_dec(input logic [15:0] v);
        logic [15:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        for (int k = 0; k < 4; k++) begin
            if (borrow) begin
                if (v[4*k+:4] == 4'h0) begin
                    r[4*k+:4] = 4'h9;
                end else begin
                    r[4*k+:4] = v[4*k+:4] - 4'h1;
                    borrow = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // One step down, binary or decimal
    function automatic logic [16:0] tcml_dec(input logic [16:0] c, input logic b);
        logic [15:0] d;
        d = b ? tcml_bcd_dec(c[15:0]) : c[15:0] - 16'h0001;
        return {1'b0, d};
    endfunction

    // Effective count from the reload value
    function automatic logic [16:0] tcml_eff(input logic [15:0] r, input tcml_mode_e m);
        logic [16:0] e;
        e = {1'b0, r};
        if (r == 16'h0000) begin
            e = TCML_CNT_MAX;
        end else if (m == TCML_M_SQUARE && {1'b0, r} == TCML_CNT_ONE) begin
            e = TCML_CNT_MAX_SQ;
        end
        return e;
    endfunction

    // Register byte seen by a read
    function automatic logic [7:0] tcml_rbyte(input tcml_chan_s c);
        logic [15:0] v;
        logic [7:0] b;
        v = c.latched ? c.latch : c.cnt[15:0];
        b = v[7:0];
        if (c.fmt == TCML_F_MSB || (c.fmt == TCML_F_BOTH && c.rd_msb)) begin
            b = v[15:8];
        end
        return b;
    endfunction

    // =========================================================
    // State
    tcml_state_s st_reg;
    tcml_state_s st_next;
    logic take;
    logic addr_ok;
    logic [1:0] idx;
    logic [2:0] cedge;

    // Bus qualifiers
    assign take = psel & penable & st_reg.rdy;
    assign addr_ok = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'b00);
    assign idx = paddr[3:2];

    // Count clock rising edges, one per channel
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_edge
            assign cedge[g] = count_clock_in[g] & ~st_reg.ch[g].clk_q;
        end
    endgenerate

    // =========================================================
    // Next state
    always_comb begin
        tcml_chan_s c;
        logic rise;
        logic [16:0] d;
        logic [16:0] n;
        c = st_reg.ch[0];
        rise = 1'b0;
        d = TCML_CNT_RESET;
        n = TCML_CNT_RESET;
        st_next = st_reg;
        st_next.rdy = psel & penable & ~st_reg.rdy;
        st_next.err = 1'b0;
        for (int i = 0; i < 3; i++) begin
            c = st_reg.ch[i];
            c.clk_q = count_clock_in[i];
            n = tcml_eff(c.reload, c.mode);
            if (cedge[i]) begin
                rise = count_gate_in[i] & ~c.gate_q;
                c.gate_q = count_gate_in[i];
                d = tcml_dec(c.cnt, c.bcd);
                case (c.mode)
                    TCML_M_TC, TCML_M_SW_STROBE: begin
                        if (c.mode == TCML_M_SW_STROBE && rise && c.armed) begin
                            c.load_pend = 1'b1;
                        end
                        if (c.load_pend) begin
                            c.cnt = n;
                            c.load_pend = 1'b0;
                            c.armed = 1'b1;
                        end else if (c.mode == TCML_M_SW_STROBE && !c.out) begin
                            c.out = 1'b1;
                        end else if (c.armed && count_gate_in[i]) begin
                            c.cnt = d;
                            if (d == TCML_CNT_RESET) begin
                                if (c.mode == TCML_M_TC) begin
                                    c.out = 1'b1;
                                end else begin
                                    c.out = 1'b0;
                                    c.armed = 1'b0;
                                end
                            end
                        end
                    end
                    TCML_M_ONESHOT, TCML_M_HW_STROBE: begin
                        if (rise) begin
                            c.cnt = n;
                            c.armed = 1'b1;
                            if (c.mode == TCML_M_ONESHOT) begin
                                c.out = 1'b0;
                            end else begin
                                c.out = 1'b1;
                            end
                        end else if (c.mode == TCML_M_HW_STROBE && !c.out) begin
                            c.out = 1'b1;
                        end else if (c.armed) begin
                            c.cnt = d;
                            if (d == TCML_CNT_RESET) begin
                                c.armed = 1'b0;
                                c.out = (c.mode == TCML_M_ONESHOT);
                            end
                        end
                    end
                    TCML_M_RATE: begin
                        if (rise || (c.load_pend && count_gate_in[i])) begin
                            c.cnt = n;
                            c.load_pend = 1'b0;
                            c.armed = 1'b1;
                            c.out = 1'b1;
                        end else if (c.armed && count_gate_in[i]) begin
                            if (c.cnt == TCML_CNT_ONE) begin
                                c.cnt = n;
                                c.out = 1'b1;
                            end else begin
                                c.cnt = d;
                                c.out = (d != TCML_CNT_ONE);
                            end
                        end
                    end
                    default: begin
                        if (rise || (c.load_pend && count_gate_in[i])) begin
                            c.cnt = (n + TCML_CNT_ONE) & ~TCML_CNT_ONE;
                            c.load_pend = 1'b0;
                            c.armed = 1'b1;
                            c.out = 1'b1;
                        end else if (c.armed && count_gate_in[i]) begin
                            if (c.cnt <= TCML_CNT_TWO) begin
                                c.out = ~c.out;
                                if (c.out) begin
                                    c.cnt = (n + TCML_CNT_ONE) & ~TCML_CNT_ONE;
                                end else begin
                                    c.cnt = n & ~TCML_CNT_ONE;
                                end
                            end else begin
                                c.cnt = c.cnt - TCML_CNT_TWO;
                            end
                        end
                    end
                endcase
            end
            // Low gate in modes 2 and 3 forces the output high
            if ((c.mode == TCML_M_RATE || c.mode == TCML_M_SQUARE) && !count_gate_in[i]) begin
                c.out = 1'b1;
                c.armed = 1'b0;
            end
            // Bus access to this channel
            if (take && addr_ok && pwrite && idx == TCML_IDX_CTRL &&
                pwdata[TCML_SEL_POS+:2] == i[1:0]) begin
                if (pwdata[TCML_FMT_POS+:2] == TCML_F_LATCH) begin
                    if (!c.latched) begin
                        c.latch = st_reg.ch[i].cnt[15:0];
                        c.latched = 1'b1;
                    end
                end else begin
                    c.fmt = tcml_fmt_e'(pwdata[TCML_FMT_POS+:2]);
                    c.bcd = pwdata[TCML_BCD_POS];
                    if (pwdata[TCML_MODE_POS+1]) begin
                        c.mode = tcml_mode_e'({1'b0, pwdata[TCML_MODE_POS+:2]});
                    end else begin
                        c.mode = tcml_mode_e'(pwdata[TCML_MODE_POS+:3]);
                    end
                    c.cnt = TCML_CNT_RESET;
                    c.out = (c.mode != TCML_M_TC);
                    c.load_pend = 1'b0;
                    c.armed = 1'b0;
                    c.latched = 1'b0;
                    c.rd_msb = 1'b0;
                    c.wr_msb = 1'b0;
                end
            end else if (take && addr_ok && idx == i[1:0]) begin
                if (pwrite) begin
                    if (c.fmt == TCML_F_BOTH && !c.wr_msb) begin
                        c.reload[7:0] = pwdata[7:0];
                        c.wr_msb = 1'b1;
                        if (c.mode == TCML_M_TC) begin
                            c.armed = 1'b0;
                            c.load_pend = 1'b0;
                        end
                    end else begin
                        if (c.fmt == TCML_F_MSB || c.fmt == TCML_F_BOTH) begin
                            c.reload[15:8] = pwdata[7:0];
                        end else begin
                            c.reload[15:8] = 8'h00;
                        end
                        if (c.fmt == TCML_F_LSB) begin
                            c.reload[7:0] = pwdata[7:0];
                        end else if (c.fmt == TCML_F_MSB) begin
                            c.reload[7:0] = 8'h00;
                        end
                        c.wr_msb = 1'b0;
                        if (c.mode == TCML_M_TC || c.mode == TCML_M_SW_STROBE) begin
                            c.armed = 1'b0;
                            c.load_pend = 1'b1;
                            c.out = (c.mode != TCML_M_TC);
                        end else if (c.mode == TCML_M_RATE || c.mode == TCML_M_SQUARE) begin
                            c.load_pend = ~c.armed;
                        end
                    end
                end else begin
                    if (c.fmt != TCML_F_BOTH || c.rd_msb) begin
                        c.latched = 1'b0;
                    end
                    if (c.fmt == TCML_F_BOTH) begin
                        c.rd_msb = ~c.rd_msb;
                    end
                end
            end
            st_next.ch[i] = c;
        end
        // Read data and error, ready for the completing edge
        if (psel && penable && !st_reg.rdy) begin
            st_next.rdata = TCML_RDATA_RESET;
            st_next.err = ~addr_ok;
            if (addr_ok && !pwrite && idx != TCML_IDX_CTRL) begin
                st_next.rdata = tcml_rbyte(st_reg.ch[idx]);
            end
        end
    end

    // Registered state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from state
    assign prdata = {24'h000000, st_reg.rdata};
    assign pready = st_reg.rdy;
    assign pslverr = st_reg.err;
    assign counter_wave_out = {st_reg.ch[2].out, st_reg.ch[1].out, st_reg.ch[0].out};

    // =========================================================
    // Assertions on channel 0
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic cw0;
    logic cnt0_wr;
    assign cw0 = take && addr_ok && pwrite && idx == TCML_IDX_CTRL &&
        pwdata[TCML_SEL_POS+:2] == 2'b00 && pwdata[TCML_FMT_POS+:2] != TCML_F_LATCH;
    assign cnt0_wr = take && addr_ok && pwrite && idx == 2'b00;

    sequence cw0_mode_s(logic [2:0] m);
        cw0 && pwdata[TCML_MODE_POS+:3] == m;
    endsequence

    mode0_setup_low_a: assert property (cw0_mode_s(3'b000) |=> !counter_wave_out[0])
        else $error("mode 0 setup did not drive output low");
    oneshot_setup_high_a: assert property (cw0_mode_s(3'b001) |=> counter_wave_out[0])
        else $error("mode 1 setup did not drive output high");
    setup_clears_a: assert property (cw0 |=> st_reg.ch[0].cnt == TCML_CNT_RESET)
        else $error("control word did not clear count");
    gate_hold_a: assert property ((st_reg.ch[0].mode == TCML_M_TC && cedge[0] && !count_gate_in[0]
        && !st_reg.ch[0].load_pend && !take) |=> $stable(st_reg.ch[0].cnt))
        else $error("mode 0 counted with gate low");
    rate_gate_high_a: assert property ((st_reg.ch[0].mode == TCML_M_RATE && !count_gate_in[0]
        && !take) |=> counter_wave_out[0])
        else $error("mode 2 output not forced high by low gate");
    strobe_width_a: assert property ((st_reg.ch[0].mode == TCML_M_SW_STROBE && !counter_wave_out[0]
        && cedge[0] && !take) |=> counter_wave_out[0])
        else $error("mode 4 strobe wider than one clock");
    square_step_a: assert property ((st_reg.ch[0].mode == TCML_M_SQUARE && st_reg.ch[0].armed
        && cedge[0] && count_gate_in[0] && count_gate_in[0] == st_reg.ch[0].gate_q && !take
        && st_reg.ch[0].cnt > TCML_CNT_TWO)
        |=> st_reg.ch[0].cnt == $past(st_reg.ch[0].cnt) - TCML_CNT_TWO)
        else $error("mode 3 count did not step by two");
    latch_copy_a: assert property ((take && addr_ok && pwrite && idx == TCML_IDX_CTRL
        && pwdata[7:4] == 4'h0 && !st_reg.ch[0].latched)
        |=> st_reg.ch[0].latched && st_reg.ch[0].latch == $past(st_reg.ch[0].cnt[15:0]))
        else $error("latch command did not capture count");
    oneshot_runs_a: assert property ((st_reg.ch[0].mode == TCML_M_ONESHOT && st_reg.ch[0].armed
        && !st_reg.ch[0].bcd && cedge[0] && !count_gate_in[0] && !take
        && st_reg.ch[0].cnt > TCML_CNT_ONE)
        |=> st_reg.ch[0].cnt == $past(st_reg.ch[0].cnt) - TCML_CNT_ONE)
        else $error("mode 1 stopped on low gate");
    halt_on_write_a: assert property ((cnt0_wr && st_reg.ch[0].mode == TCML_M_TC)
        |=> !st_reg.ch[0].armed)
        else $error("mode 0 count write did not halt counting");
endmodule
`default_nettype wire

// *** pkg/tcml_pkg.sv ***
/*
 * Shared constants and types for the three-channel down-counter block:
 * register offsets, control word fields, mode and access format codes,
 * count limits and the packed state of one channel.
 * Assumes a 32-bit APB with byte addresses and one register per aligned word.
 */
package tcml_pkg;
    // =========================================================
    // Register offsets
    localparam logic [11:0] TCML_ADDR_COUNT0 = 12'h000;
    localparam logic [11:0] TCML_ADDR_COUNT1 = 12'h004;
    localparam logic [11:0] TCML_ADDR_COUNT2 = 12'h008;
    localparam logic [11:0] TCML_ADDR_CTRL = 12'h00c;
    localparam logic [1:0] TCML_IDX_CTRL = 2'h3;
    localparam logic [1:0] TCML_SEL_ILLEGAL = 2'h3;
    // =========================================================
    // Control word field positions
    localparam int TCML_SEL_POS = 6;
    localparam int TCML_FMT_POS = 4;
    localparam int TCML_MODE_POS = 1;
    localparam int TCML_BCD_POS = 0;
    // =========================================================
    // Count limits and reset values
    localparam logic [16:0] TCML_CNT_MAX = 17'h10000;
    localparam logic [16:0] TCML_CNT_MAX_SQ = 17'h10001;
    localparam logic [16:0] TCML_CNT_ONE = 17'h00001;
    localparam logic [16:0] TCML_CNT_TWO = 17'h00002;
    localparam logic [16:0] TCML_CNT_RESET = 17'h00000;
    localparam logic [15:0] TCML_RELOAD_RESET = 16'h0000;
    localparam logic [7:0] TCML_RDATA_RESET = 8'h00;

    // Operating modes
    typedef enum logic [2:0] {
        TCML_M_TC = 3'b000,
        TCML_M_ONESHOT = 3'b001,
        TCML_M_RATE = 3'b010,
        TCML_M_SQUARE = 3'b011,
        TCML_M_SW_STROBE = 3'b100,
        TCML_M_HW_STROBE = 3'b101
    } tcml_mode_e;

    // Access formats
    typedef enum logic [1:0] {
        TCML_F_LATCH = 2'b00,
        TCML_F_LSB = 2'b01,
        TCML_F_MSB = 2'b10,
        TCML_F_BOTH = 2'b11
    } tcml_fmt_e;

    // One counter channel
    typedef struct packed {
        tcml_mode_e mode;
        logic bcd;
        tcml_fmt_e fmt;
        logic [16:0] cnt;
        logic [15:0] reload;
        logic [15:0] latch;
        logic latched;
        logic rd_msb;
        logic wr_msb;
        logic load_pend;
        logic armed;
        logic out;
        logic gate_q;
        logic clk_q;
    } tcml_chan_s;

    // Whole block state
    typedef struct packed {
        tcml_chan_s [2:0] ch;
        logic rdy;
        logic err;
        logic [7:0] rdata;
    } tcml_state_s;
endpackage

// *** bench/tcml_cnt_src.sv ***
/*
 * Count clock source for the three channels, standing in for the far side.
 * Assumes pclk is the bench clock; run low holds every count clock still.
 */
`timescale 1ns/1ps
`default_nettype none
module tcml_cnt_src (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    output logic [2:0] count_clock_in
);
    logic ph_reg;
    // Four pclk periods per count, low while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_reg <= 1'b0;
            count_clock_in <= 3'h0;
        end else if (run) begin
            ph_reg <= ~ph_reg;
            if (ph_reg) begin
                count_clock_in <= ~count_clock_in;
            end
        end else begin
            ph_reg <= 1'b0;
            count_clock_in <= 3'h0;
        end
    end
endmodule
`default_nettype wire

// *** bench/tcml_top_tb.sv ***
/*
 * Self-checking bench for the three-channel counter block.
 * Assumes a one-wait-state APB slave and a count clock edge every 4 pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module tcml_top_tb
    import tcml_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, run;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, er;
    logic [2:0] cclk, gate, wave;
    logic [15:0] v1, v2;
    int n_fail, check_count, n;

    tcml_cnt_src src (.pclk(pclk), .presetn(presetn), .run(run), .count_clock_in(cclk));
    tcml_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .count_clock_in(cclk),
        .count_gate_in(gate), .counter_wave_out(wave));

    // =========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Latch command then a low/high byte read of one channel
    task automatic latch16(input logic [1:0] c, output logic [15:0] v);
        apb(1'b1, TCML_ADDR_CTRL, {c, 6'h00});
        apb(1'b0, {8'h0, c, 2'b00}, 8'h00);
        v[7:0] = rd[7:0];
        apb(1'b0, {8'h0, c, 2'b00}, 8'h00);
        v[15:8] = rd[7:0];
    endtask
    task automatic wait_lvl(input int c, input logic v);
        for (int i = 0; i < 300 && wave[c] !== v; i++) @(posedge pclk);
    endtask
    task automatic run_len(input int c, input logic v, output int k);
        k = 0;
        while (wave[c] === v && k < 300) begin
            @(posedge pclk);
            k++;
        end
    endtask
    // Measure one low run and the following high run
    task automatic measure(input int c, input int lo, input int hi);
        wait_lvl(c, 1'b1);
        wait_lvl(c, 1'b0);
        run_len(c, 1'b0, n);
        chk(n, lo);
        run_len(c, 1'b1, n);
        chk(n, hi);
    endtask

    // =========================================================
    // Scenarios
    task automatic t_err();
        apb(1'b0, 12'h010, 8'h00);
        chk(er, 32'h1);
        apb(1'b0, TCML_ADDR_CTRL, 8'h00);
        chk(er, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_mode0();
        gate[0] <= 1'b0;
        apb(1'b1, TCML_ADDR_CTRL, 8'h10);
        apb(1'b1, TCML_ADDR_COUNT0, 8'h04);
        repeat (40) @(posedge pclk);
        chk(wave[0], 32'h0);
        gate[0] <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(wave[0], 32'h0);
        repeat (20) @(posedge pclk);
        chk(wave[0], 32'h1);
        apb(1'b1, TCML_ADDR_CTRL, 8'h10);
        repeat (2) @(posedge pclk);
        chk(wave[0], 32'h0);
    endtask
    task automatic t_rate(input logic [1:0] c, input logic [2:0] m);
        apb(1'b1, TCML_ADDR_CTRL, {c, 2'b01, m, 1'b0});
        apb(1'b1, {8'h0, c, 2'b00}, 8'h03);
        measure(c, 4, 8);
        gate[c] <= 1'b0;
        repeat (24) @(posedge pclk);
        chk(wave[c], 32'h1);
        gate[c] <= 1'b1;
        measure(c, 4, 8);
    endtask
    task automatic t_oneshot(input logic [1:0] c);
        gate[c] <= 1'b0;
        apb(1'b1, TCML_ADDR_CTRL, {c, 6'h12});
        apb(1'b1, {8'h0, c, 2'b00}, 8'h03);
        repeat (30) @(posedge pclk);
        chk(wave[c], 32'h1);
        gate[c] <= 1'b1;
        wait_lvl(c, 1'b0);
        gate[c] <= 1'b0;
        run_len(c, 1'b0, n);
        chk(n, 32'd12);
        // New count, then a fresh trigger runs it
        apb(1'b1, {8'h0, c, 2'b00}, 8'h05);
        gate[c] <= 1'b1;
        wait_lvl(c, 1'b0);
        run_len(c, 1'b0, n);
        chk(n, 32'd20);
    endtask
    task automatic t_square(input logic [1:0] c);
        apb(1'b1, TCML_ADDR_CTRL, {c, 6'h16});
        apb(1'b1, {8'h0, c, 2'b00}, 8'h05);
        measure(c, 8, 12);
    endtask
    // Strobe modes 4 and 5, and a decimal count
    task automatic t_strobe();
        apb(1'b1, TCML_ADDR_CTRL, 8'h18);
        apb(1'b1, TCML_ADDR_COUNT0, 8'h03);
        wait_lvl(0, 1'b0);
        run_len(0, 1'b0, n);
        chk(n, 32'd4);
        run_len(0, 1'b1, n);
        chk(n, 32'd300);
        gate[2] <= 1'b0;
        apb(1'b1, TCML_ADDR_CTRL, 8'h9a);
        apb(1'b1, TCML_ADDR_COUNT2, 8'h02);
        repeat (8) @(posedge pclk);
        gate[2] <= 1'b1;
        wait_lvl(2, 1'b0);
        run_len(2, 1'b0, n);
        chk(n, 32'd4);
        apb(1'b1, TCML_ADDR_CTRL, 8'h51);
        apb(1'b1, TCML_ADDR_COUNT1, 8'h10);
        repeat (32) @(posedge pclk);
        chk(wave[1], 32'h0);
        repeat (16) @(posedge pclk);
        chk(wave[1], 32'h1);
    endtask
    task automatic t_latch();
        apb(1'b1, TCML_ADDR_CTRL, 8'h30);
        apb(1'b1, TCML_ADDR_COUNT0, 8'h00);
        apb(1'b1, TCML_ADDR_COUNT0, 8'h10);
        repeat (40) @(posedge pclk);
        latch16(2'b00, v1);
        chk(v1 <= 16'h1000 && v1 > 16'h0fe0, 32'h1);
        latch16(2'b00, v2);
        chk(v2 < v1, 32'h1);
        apb(1'b1, TCML_ADDR_COUNT0, 8'h50);
        latch16(2'b00, v1);
        repeat (20) @(posedge pclk);
        latch16(2'b00, v2);
        chk(v2, v1);
        apb(1'b1, TCML_ADDR_COUNT0, 8'h00);
        repeat (20) @(posedge pclk);
        latch16(2'b00, v1);
        chk(v1 <= 16'h0050 && v1 > 16'h0040, 32'h1);
        // Count clock frozen: direct read equals latched value
        run <= 1'b0;
        repeat (4) @(posedge pclk);
        latch16(2'b00, v1);
        apb(1'b0, TCML_ADDR_COUNT0, 8'h00);
        v2[7:0] = rd[7:0];
        apb(1'b0, TCML_ADDR_COUNT0, 8'h00);
        v2[15:8] = rd[7:0];
        chk(v2, v1);
        run <= 1'b1;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        gate = 3'h7;
        run = 1'b1;
        n_fail = 0;
        check_count = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_err();
        t_mode0();
        t_rate(2'd0, 3'b110);
        t_rate(2'd1, 3'b010);
        t_oneshot(2'd0);
        t_oneshot(2'd1);
        t_square(2'd0);
        t_square(2'd2);
        t_latch();
        t_strobe();
        tally_and_finish();
    end
endmodule
`default_nettype wire
